/* common/ips_consts.svh */
// Function
// [R01] sda changes only while scl low
// [R02] write is address, register, then data
// [R03] select high answers 0x20, 0x22, 0x25
// [R04] select low answers 0x40, 0x42, 0x45
// [R05] read opens with write-direction address, register
// [R06] register byte is 8-bit page address
// [R07] repeated start turns transaction into read
// [R08] master resends page address with read bit
// [R09] read data driven after address acknowledge
// [R10] eeprom page bit 7 selects cache
// [R11] control page 0x30 holds dac code
// [R12] commands accepted only while hold bit 0
// [R13] commands decoded only from page 0, 0x09
// [R14] command 0x00 captures pressure adc sample
// [R15] command 0x02 captures temperature adc sample
// [R16] command 0x04 returns compensated output sample
// [R17] command 0x06 loads diagnostic status
// [R18] response msb at 0x05, lsb at 0x04
// [R19] command 0x70 reloads lower 16 result bits
// [R20] config access needs select and hold set
// [R21] select pin steady during a transaction
// [R22] ignore transactions to foreign addresses
// [R23] acknowledge matched address, register, data bytes
`ifndef IPS_CONSTS_SVH
`define IPS_CONSTS_SVH

// slave addresses, select pin high and low
`define IPS_ADDR_P0_HI   7'h20
`define IPS_ADDR_P2_HI   7'h22
`define IPS_ADDR_P5_HI   7'h25
`define IPS_ADDR_P0_LO   7'h40
`define IPS_ADDR_P2_LO   7'h42
`define IPS_ADDR_P5_LO   7'h45

// page indices
`define IPS_PAGE_DATA    8'h00
`define IPS_PAGE_CTRL    8'h02
`define IPS_PAGE_EE      8'h05

// register offsets
`define IPS_REG_CMD      8'h09
`define IPS_REG_RESP_LO  8'h04
`define IPS_REG_RESP_HI  8'h05
`define IPS_REG_DAC      8'h30
`define IPS_EE_CACHE_BIT 7

// runtime command codes
`define IPS_CMD_PRESSURE_ADC     8'h00
`define IPS_CMD_TEMP_ADC     8'h02
`define IPS_CMD_COMP     8'h04
`define IPS_CMD_DIAG     8'h06
`define IPS_CMD_TRAIL    8'h70

// counts and reset values
`define IPS_BYTE_BITS    4'h8
`define IPS_RST_BYTE     8'h00
`define IPS_RST_WORD     16'h0000
`define IPS_RST_SAMPLE   24'h000000

`endif

/* common/ips_pkg.sv */
package ips_pkg;

  // transaction state, one-hot
  typedef enum logic [10:0] {
    IPS_IDLE      = 11'h001,
    IPS_ADDR      = 11'h002,
    IPS_ADDR_ACK  = 11'h004,
    IPS_REG       = 11'h008,
    IPS_REG_ACK   = 11'h010,
    IPS_WDATA     = 11'h020,
    IPS_WDATA_ACK = 11'h040,
    IPS_RDATA     = 11'h080,
    IPS_RACK      = 11'h100,
    IPS_RNEXT     = 11'h200,
    IPS_IGNORE    = 11'h400
  } ips_state_type;

endpackage

/* common/ips_line_if.sv */
`timescale 1ns/1ps
interface ips_line_if;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic sda;

  modport src (output rise, output fall, output start, output stop, output sda);
  modport dst (input rise, input fall, input start, input stop, input sda);
endinterface

/* design/ips_line_sync.sv */
`timescale 1ns/1ps
`include "ips_consts.svh"
module ips_line_sync (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  ips_line_if.src   ln
);
  logic scl_q1;
  logic scl_q2;
  logic scl_q3;
  logic sda_q1;
  logic sda_q2;
  logic sda_q3;

  // two-stage synchronisers; third stage only for edge finding
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      scl_q1 <= 1'b1;
      scl_q2 <= 1'b1;
      scl_q3 <= 1'b1;
      sda_q1 <= 1'b1;
      sda_q2 <= 1'b1;
      sda_q3 <= 1'b1;
    end else begin
      scl_q1 <= scl_in;
      scl_q2 <= scl_q1;
      scl_q3 <= scl_q2;
      sda_q1 <= sda_in;
      sda_q2 <= sda_q1;
      sda_q3 <= sda_q2;
    end
  end

  // both lines share the same delay, so data edges keep their order to scl
  assign ln.rise  = scl_q2 & ~scl_q3;
  assign ln.fall  = ~scl_q2 & scl_q3;
  assign ln.start = scl_q2 & scl_q3 & sda_q3 & ~sda_q2; // see [R01]
  assign ln.stop  = scl_q2 & scl_q3 & ~sda_q3 & sda_q2; // see [R01]
  assign ln.sda   = sda_q2;
endmodule

/* design/ips_paged_slave.sv */
`timescale 1ns/1ps
`include "ips_consts.svh"
module ips_paged_slave #(
  parameter int SAMPLE_W = 24,
  parameter int DIAG_W   = 16
) (
  input  wire logic                clk_in,
  input  wire logic                nrst_in,
  input  wire logic                scl_in,
  input  wire logic                sda_in,
  output logic                     sda_out,
  output logic                     sda_oe_out,
  input  wire logic                addr_select_pin_in,
  input  wire logic                interface_select_in,
  input  wire logic                comp_hold_in,
  input  wire logic                wide_sample_en_in,
  input  wire logic [SAMPLE_W-1:0] pressure_adc_in,
  input  wire logic [SAMPLE_W-1:0] temp_adc_in,
  input  wire logic [SAMPLE_W-1:0] comp_output_in,
  input  wire logic [DIAG_W-1:0]   diag_status_in,
  input  wire logic [7:0]          reg_rdata_in,
  output logic                     reg_wr_out,
  output logic                     reg_rd_out,
  output logic [7:0]               reg_page_out,
  output logic [7:0]               reg_addr_out,
  output logic [7:0]               reg_wdata_out,
  output logic                     ee_cache_sel_out,
  output logic [7:0]               dac_code_part_out,
  output logic [15:0]              response_out
);
  ips_line_if ln ();

  ips_pkg::ips_state_type st;
  logic                   sel_q1;
  logic                   sel_q2;
  logic [3:0]             cnt;
  logic [7:0]             shreg;
  logic [7:0]             tx;
  logic                   oe;
  logic                   rw;
  logic                   mack;
  logic [7:0]             page;
  logic [7:0]             reg_addr;
  logic                   cmd_go;
  logic [7:0]             cmd_code;
  logic                   wr_go;
  logic                   rd_go;
  logic [7:0]             wdata;
  logic [7:0]             dac_code;
  logic [15:0]            resp;
  logic [23:0]            result;
  logic                   cfg_ok;
  logic [7:0]             rd_byte;
  logic [8:0]             hit_page;

  ips_line_sync u_sync (
    .clk_in  (clk_in),
    .nrst_in (nrst_in),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .ln      (ln)
  );

  // page lookup: {hit, page index} for a 7-bit address
  function automatic logic [8:0] page_of(input logic [6:0] a, input logic sel);
    logic [8:0] r;
    r = {1'b0, `IPS_PAGE_DATA};
    if (sel) begin
      if (a == `IPS_ADDR_P0_HI) r = {1'b1, `IPS_PAGE_DATA}; // see [R03]
      if (a == `IPS_ADDR_P2_HI) r = {1'b1, `IPS_PAGE_CTRL};
      if (a == `IPS_ADDR_P5_HI) r = {1'b1, `IPS_PAGE_EE};
    end else begin
      if (a == `IPS_ADDR_P0_LO) r = {1'b1, `IPS_PAGE_DATA}; // see [R04]
      if (a == `IPS_ADDR_P2_LO) r = {1'b1, `IPS_PAGE_CTRL};
      if (a == `IPS_ADDR_P5_LO) r = {1'b1, `IPS_PAGE_EE};
    end
    return r;
  endfunction

  // response word from a 24-bit sample: top byte first, rest via trail command
  function automatic logic [15:0] top_word(input logic [23:0] s);
    return {`IPS_RST_BYTE, s[23:16]};
  endfunction

  // select pin comes from a pin, so synchronise it
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sel_q1 <= 1'b0;
      sel_q2 <= 1'b0;
    end else begin
      sel_q1 <= addr_select_pin_in; // see [R21]
      sel_q2 <= sel_q1;
    end
  end

  assign cfg_ok   = interface_select_in & comp_hold_in; // see [R20]
  assign hit_page = page_of(shreg[7:1], sel_q2);

  // byte served on a read; response always visible, config gated
  always_comb begin
    rd_byte = `IPS_RST_BYTE;
    if (page == `IPS_PAGE_DATA && reg_addr == `IPS_REG_RESP_LO) begin
      rd_byte = resp[7:0]; // see [R18]
    end else if (page == `IPS_PAGE_DATA && reg_addr == `IPS_REG_RESP_HI) begin
      rd_byte = resp[15:8]; // see [R18]
    end else if (!cfg_ok) begin
      rd_byte = `IPS_RST_BYTE; // see [R20]
    end else if (page == `IPS_PAGE_CTRL && reg_addr == `IPS_REG_DAC) begin
      rd_byte = dac_code; // see [R11]
    end else begin
      rd_byte = reg_rdata_in;
    end
  end

  // transaction sequencer; start and stop override any state
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st       <= ips_pkg::IPS_IDLE;
      cnt      <= 4'h0;
      shreg    <= `IPS_RST_BYTE;
      tx       <= `IPS_RST_BYTE;
      oe       <= 1'b0;
      rw       <= 1'b0;
      mack     <= 1'b0;
      page     <= `IPS_PAGE_DATA;
      reg_addr <= `IPS_RST_BYTE;
      cmd_go   <= 1'b0;
      cmd_code <= `IPS_RST_BYTE;
      wr_go    <= 1'b0;
      rd_go    <= 1'b0;
      wdata    <= `IPS_RST_BYTE;
    end else begin
      cmd_go <= 1'b0;
      wr_go  <= 1'b0;
      rd_go  <= 1'b0;
      if (ln.stop) begin
        st <= ips_pkg::IPS_IDLE;
        oe <= 1'b0;
      end else if (ln.start) begin
        // a repeated start after the register byte leads into a read
        st  <= ips_pkg::IPS_ADDR; // see [R07]
        cnt <= 4'h0;
        oe  <= 1'b0;
      end else begin
        unique case (st)
          ips_pkg::IPS_IDLE, ips_pkg::IPS_IGNORE: begin
            oe <= 1'b0; // see [R22]
          end
          ips_pkg::IPS_ADDR, ips_pkg::IPS_REG, ips_pkg::IPS_WDATA: begin
            if (ln.rise) begin
              shreg <= {shreg[6:0], ln.sda}; // see [R01]
              cnt   <= cnt + 4'h1;
            end else if (ln.fall && cnt == `IPS_BYTE_BITS) begin
              cnt <= 4'h0;
              if (st == ips_pkg::IPS_ADDR) begin
                if (hit_page[8]) begin
                  page <= hit_page[7:0];
                  rw   <= shreg[0]; // see [R05] [R08]
                  rd_go <= shreg[0];
                  oe   <= 1'b1; // see [R23]
                  st   <= ips_pkg::IPS_ADDR_ACK;
                end else begin
                  st <= ips_pkg::IPS_IGNORE; // see [R22]
                end
              end else if (st == ips_pkg::IPS_REG) begin
                reg_addr <= shreg; // see [R06]
                oe       <= 1'b1; // see [R23]
                st       <= ips_pkg::IPS_REG_ACK;
              end else begin
                oe <= 1'b1; // see [R23]
                st <= ips_pkg::IPS_WDATA_ACK;
                if (page == `IPS_PAGE_DATA && reg_addr == `IPS_REG_CMD) begin
                  // commands only run while compensation is live
                  cmd_go   <= ~comp_hold_in; // see [R12] [R13]
                  cmd_code <= shreg;
                end else if (cfg_ok) begin
                  wr_go <= 1'b1; // see [R02] [R20]
                  wdata <= shreg;
                end
              end
            end
          end
          ips_pkg::IPS_ADDR_ACK: begin
            if (ln.fall) begin
              if (rw) begin
                // first data bit goes out on the fall that ends the ack
                tx  <= rd_byte; // see [R09]
                oe  <= ~rd_byte[7];
                cnt <= 4'h0;
                st  <= ips_pkg::IPS_RDATA;
              end else begin
                oe <= 1'b0;
                st <= ips_pkg::IPS_REG;
              end
            end
          end
          ips_pkg::IPS_REG_ACK: begin
            if (ln.fall) begin
              oe <= 1'b0;
              st <= ips_pkg::IPS_WDATA;
            end
          end
          ips_pkg::IPS_WDATA_ACK: begin
            // only one data byte per write; the rest is ignored
            if (ln.fall) begin
              oe <= 1'b0;
              st <= ips_pkg::IPS_IGNORE;
            end
          end
          ips_pkg::IPS_RDATA: begin
            if (ln.rise) begin
              cnt <= cnt + 4'h1;
            end else if (ln.fall) begin
              if (cnt == `IPS_BYTE_BITS) begin
                oe <= 1'b0;
                st <= ips_pkg::IPS_RACK;
              end else begin
                tx <= {tx[6:0], 1'b0}; // see [R01]
                oe <= ~tx[6];
              end
            end
          end
          ips_pkg::IPS_RACK: begin
            if (ln.rise) begin
              mack <= ~ln.sda;
            end else if (ln.fall) begin
              if (mack) begin
                reg_addr <= reg_addr + 8'h01;
                rd_go    <= 1'b1;
                st       <= ips_pkg::IPS_RNEXT;
              end else begin
                st <= ips_pkg::IPS_IGNORE;
              end
            end
          end
          ips_pkg::IPS_RNEXT: begin
            // one cycle lets the incremented address reach the read mux
            tx  <= rd_byte;
            oe  <= ~rd_byte[7];
            cnt <= 4'h0;
            st  <= ips_pkg::IPS_RDATA;
          end
          default: begin
            st <= ips_pkg::IPS_IDLE;
            oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // dac code register on the control page
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dac_code <= `IPS_RST_BYTE;
    end else if (wr_go && page == `IPS_PAGE_CTRL && reg_addr == `IPS_REG_DAC) begin
      dac_code <= wdata; // see [R11]
    end
  end

  // runtime command execution; unknown codes leave the response alone
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      resp   <= `IPS_RST_WORD;
      result <= `IPS_RST_SAMPLE;
    end else if (cmd_go) begin
      case (cmd_code)
        `IPS_CMD_PRESSURE_ADC: begin
          result <= 24'(pressure_adc_in); // see [R14]
          resp   <= top_word(24'(pressure_adc_in));
        end
        `IPS_CMD_TEMP_ADC: begin
          result <= 24'(temp_adc_in); // see [R15]
          resp   <= top_word(24'(temp_adc_in));
        end
        `IPS_CMD_COMP: begin
          // narrow mode answers the whole word at once
          if (wide_sample_en_in) begin
            result <= 24'(comp_output_in); // see [R16]
            resp   <= top_word(24'(comp_output_in));
          end else begin
            result <= {`IPS_RST_BYTE, comp_output_in[15:0]}; // see [R16]
            resp   <= comp_output_in[15:0];
          end
        end
        `IPS_CMD_DIAG: begin
          result <= 24'(diag_status_in); // see [R17]
          resp   <= 16'(diag_status_in);
        end
        `IPS_CMD_TRAIL: begin
          resp <= result[15:0]; // see [R19]
        end
        default: begin
          resp <= resp;
        end
      endcase
    end
  end

  // open drain: only ever pulls low
  assign sda_out           = 1'b0;
  assign sda_oe_out        = oe;
  assign reg_wr_out        = wr_go;
  assign reg_rd_out        = rd_go;
  assign reg_page_out      = page;
  assign reg_addr_out      = reg_addr;
  assign reg_wdata_out     = wdata;
  assign ee_cache_sel_out  = (page == `IPS_PAGE_EE) & reg_addr[`IPS_EE_CACHE_BIT]; // see [R10]
  assign dac_code_part_out = dac_code;
  assign response_out      = resp;
endmodule

/* tb/ips_master_model.sv */
`timescale 1ns/1ps
// bus master stand-in; one bit takes eight system clocks
module ips_master_model (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_oe_out
);
  // idle bus: clock parked high, data released to the pull-up
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // start and repeated start share one shape
  task automatic start();
    tick(2);
    sda_oe_out = 1'b0;
    tick(2);
    scl_out = 1'b1;
    tick(2);
    sda_oe_out = 1'b1;
    tick(2);
    scl_out = 1'b0;
  endtask
  // data rises while clock high, then the bus is let go
  task automatic stop();
    tick(2);
    sda_oe_out = 1'b1;
    tick(2);
    scl_out = 1'b1;
    tick(2);
    sda_oe_out = 1'b0;
    tick(4);
  endtask
  // eight bits msb first, then the acknowledge slot; d of all ones reads
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ack);
    logic [8:0] w;
    w = {d, a};
    for (int i = 8; i >= 0; i--) begin
      tick(2);
      sda_oe_out = ~w[i];
      tick(2);
      scl_out = 1'b1;
      tick(3);
      if (i > 0) begin
        q[i-1] = sda_in;
      end else begin
        ack = sda_in;
      end
      tick(1);
      scl_out = 1'b0;
    end
  endtask
endmodule

/* tb/ips_paged_slave_asserts.sv */
`timescale 1ns/1ps
module ips_paged_slave_asserts (
  input wire logic        clk_in,
  input wire logic        nrst_in,
  input wire logic        scl_in,
  input wire logic        sda_oe_out,
  input wire logic        interface_select_in,
  input wire logic        comp_hold_in,
  input wire logic        reg_wr_out,
  input wire logic [7:0]  reg_page_out,
  input wire logic [7:0]  reg_addr_out,
  input wire logic [7:0]  reg_wdata_out,
  input wire logic        ee_cache_sel_out,
  input wire logic [7:0]  dac_code_part_out,
  input wire logic [15:0] response_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // one full clock-high phase; bounded so a stuck line shows up
  sequence s_scl_high;
    ##[0:20] $rose(scl_in) ##[1:20] $fell(scl_in);
  endsequence
  // the only slot from which commands are decoded
  sequence s_cmd_slot;
    !comp_hold_in && reg_page_out == 8'h00 && reg_addr_out == 8'h09;
  endsequence
  // pin level checks; scl is judged at the edge on which the enable moved
  oe_scl_low_a: assert property ($changed(sda_oe_out) |-> !$past(scl_in))
    else $error("data driven while clock high");
  oe_hold_a: assert property ($rose(sda_oe_out) |-> sda_oe_out throughout s_scl_high)
    else $error("pulled data released early");
  // register side effects; page 2 register 0x09 is an ordinary config write
  wr_pulse_a: assert property (reg_wr_out |=> !reg_wr_out)
    else $error("write strobe longer than one cycle");
  wr_gate_a: assert property (reg_wr_out |-> interface_select_in && comp_hold_in &&
    !(reg_page_out == 8'h00 && reg_addr_out == 8'h09))
    else $error("config write while gated");
  page_legal_a: assert property (reg_page_out inside {8'h00, 8'h02, 8'h05})
    else $error("page index out of set");
  cache_sel_a: assert property (ee_cache_sel_out == (reg_page_out == 8'h05 && reg_addr_out[7]))
    else $error("cache select wrong");
  dac_update_a: assert property ($changed(dac_code_part_out) |->
    reg_page_out == 8'h02 && reg_addr_out == 8'h30 && dac_code_part_out == reg_wdata_out)
    else $error("dac code moved without its write");
  resp_cause_a: assert property ($changed(response_out) |-> s_cmd_slot)
    else $error("response moved without a command");
endmodule
bind ips_paged_slave ips_paged_slave_asserts i_ips_paged_slave_asserts (.clk_in, .nrst_in, .scl_in,
  .sda_oe_out, .interface_select_in, .comp_hold_in, .reg_wr_out, .reg_page_out, .reg_addr_out,
  .reg_wdata_out, .ee_cache_sel_out, .dac_code_part_out, .response_out);

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic        clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic        addr_select_pin_in = 1'b1;
  logic        interface_select_in = 1'b1;
  logic        comp_hold_in = 1'b1;
  logic        wide_sample_en_in = 1'b1;
  logic [23:0] pressure_adc_in = 24'h123456;
  logic [23:0] temp_adc_in = 24'habcdef;
  logic [23:0] comp_output_in = 24'h13579b;
  logic [15:0] diag_status_in = 16'hbeef;
  logic [7:0]  reg_rdata_in, reg_page_out, reg_addr_out, reg_wdata_out, dac_code_part_out;
  logic [15:0] response_out;
  logic        scl_in, sda_in, sda_out, sda_oe_out, m_oe, reg_wr_out, reg_rd_out, ee_cache_sel_out;
  int          num_errors = 0;
  int          n_compared = 0;
  int          n_rd = 0;
  int          n_wr = 0;

  always #50 clk_in = ~clk_in;
  // open-drain wire with pull-up: low if either side pulls
  assign sda_in = ~m_oe & (~sda_oe_out | sda_out);
  // register store stand-in, address xor page xor 0x5a per page and address
  assign reg_rdata_in = reg_addr_out ^ reg_page_out ^ 8'h5a;
  // strobe counters, read mid-cycle where the one-cycle pulses are settled
  always @(negedge clk_in) begin
    if (reg_rd_out === 1'b1) begin
      n_rd++;
    end
    if (reg_wr_out === 1'b1) begin
      n_wr++;
    end
  end

  ips_paged_slave i_ips_paged_slave (.clk_in, .nrst_in, .scl_in, .sda_in, .sda_out, .sda_oe_out,
    .addr_select_pin_in, .interface_select_in, .comp_hold_in, .wide_sample_en_in, .pressure_adc_in,
    .temp_adc_in, .comp_output_in, .diag_status_in, .reg_rdata_in, .reg_wr_out, .reg_rd_out,
    .reg_page_out, .reg_addr_out, .reg_wdata_out, .ee_cache_sel_out, .dac_code_part_out, .response_out);
  ips_master_model i_ips_master_model (.clk_in, .sda_in, .scl_out(scl_in), .sda_oe_out(m_oe));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // address, register, data; ea holds the three expected ack bits
  task automatic wr(input logic [6:0] sa, input logic [7:0] ra, input logic [7:0] d, input logic [2:0] ea);
    logic [7:0] q;
    logic [2:0] a;
    i_ips_master_model.start();
    i_ips_master_model.xfer({sa, 1'b0}, 1'b1, q, a[2]);
    i_ips_master_model.xfer(ra, 1'b1, q, a[1]);
    i_ips_master_model.xfer(d, 1'b1, q, a[0]);
    i_ips_master_model.stop();
    chk(16'(a), 16'(ea));
  endtask
  // one byte read, closed by a master nack; exactly one read strobe
  task automatic rd(input logic [6:0] sa, input logic [7:0] ra, output logic [7:0] q);
    logic a;
    int   n0;
    n0 = n_rd;
    i_ips_master_model.start();
    i_ips_master_model.xfer({sa, 1'b0}, 1'b1, q, a);
    i_ips_master_model.xfer(ra, 1'b1, q, a);
    i_ips_master_model.start();
    i_ips_master_model.xfer({sa, 1'b1}, 1'b1, q, a);
    i_ips_master_model.xfer(8'hff, 1'b1, q, a);
    i_ips_master_model.stop();
    chk(16'(n_rd - n0), 16'h0001);
  endtask
  task automatic t_pages();
    logic [7:0] pg;
    for (int s = 0; s < 2; s++) begin
      addr_select_pin_in = s[0];
      for (int p = 0; p < 3; p++) begin
        pg = (p == 0) ? 8'h00 : (p == 1) ? 8'h02 : 8'h05;
        wr((s ? 7'h20 : 7'h40) | pg[6:0], 8'h11, 8'h3c + pg, 3'b000);
        chk(16'(reg_page_out), 16'(pg));
        chk(16'(reg_addr_out), 16'h0011);
        chk(16'(reg_wdata_out), 16'(8'h3c + pg));
      end
      wr(s ? 7'h40 : 7'h20, 8'h30, 8'h77, 3'b111);
      chk(16'(reg_wdata_out), 16'h0041);
    end
    chk(16'(n_wr), 16'h0006);
  endtask
  task automatic t_dac();
    logic [7:0] q;
    wr(7'h22, 8'h30, 8'h80, 3'b000);
    chk(16'(dac_code_part_out), 16'h0080);
    comp_hold_in = 1'b0;
    wr(7'h22, 8'h30, 8'h55, 3'b000);
    chk(16'(dac_code_part_out), 16'h0080);
    comp_hold_in = 1'b1;
    interface_select_in = 1'b0;
    rd(7'h25, 8'h07, q);
    chk(16'(q), 16'h0000);
    interface_select_in = 1'b1;
    chk(16'(n_wr), 16'h0007);
  endtask
  task automatic t_read();
    logic [7:0] q;
    logic [7:0] q2;
    logic       a;
    int         n0;
    rd(7'h25, 8'h87, q);
    chk(16'(q), 16'(8'h87 ^ 8'h05 ^ 8'h5a));
    chk(16'(ee_cache_sel_out), 16'h0001);
    rd(7'h25, 8'h07, q);
    chk(16'(q), 16'(8'h07 ^ 8'h05 ^ 8'h5a));
    chk(16'(ee_cache_sel_out), 16'h0000);
    // master acks the first byte, so the next address is served after it
    n0 = n_rd;
    i_ips_master_model.start();
    i_ips_master_model.xfer({7'h25, 1'b0}, 1'b1, q, a);
    i_ips_master_model.xfer(8'h86, 1'b1, q, a);
    i_ips_master_model.start();
    i_ips_master_model.xfer({7'h25, 1'b1}, 1'b1, q, a);
    i_ips_master_model.xfer(8'hff, 1'b0, q, a);
    i_ips_master_model.xfer(8'hff, 1'b1, q2, a);
    i_ips_master_model.stop();
    chk(16'(q), 16'(8'h86 ^ 8'h05 ^ 8'h5a));
    chk(16'(q2), 16'(8'h87 ^ 8'h05 ^ 8'h5a));
    chk(16'(reg_addr_out), 16'h0087);
    chk(16'(ee_cache_sel_out), 16'h0001);
    chk(16'(n_rd - n0), 16'h0002);
  endtask
  // command, then both response bytes read back over the bus
  task automatic cmd(input logic [6:0] sa, input logic [7:0] c, input logic [15:0] e);
    logic [7:0] q;
    wr(sa, 8'h09, c, 3'b000);
    rd(7'h40, 8'h05, q);
    chk(16'(q), 16'(e[15:8]));
    rd(7'h40, 8'h04, q);
    chk(16'(q), 16'(e[7:0]));
    chk(response_out, e);
  endtask
  task automatic t_cmds();
    addr_select_pin_in = 1'b0;
    comp_hold_in = 1'b0;
    cmd(7'h40, 8'h00, 16'h0012);
    cmd(7'h40, 8'h70, 16'h3456);
    cmd(7'h40, 8'h02, 16'h00ab);
    cmd(7'h40, 8'h70, 16'hcdef);
    cmd(7'h40, 8'h04, 16'h0013);
    cmd(7'h40, 8'h70, 16'h579b);
    cmd(7'h40, 8'h06, 16'hbeef);
    wide_sample_en_in = 1'b0;
    cmd(7'h40, 8'h04, 16'h579b);
    comp_hold_in = 1'b1;
    cmd(7'h40, 8'h02, 16'h579b);
    comp_hold_in = 1'b0;
    cmd(7'h42, 8'h06, 16'h579b);
    chk(16'(n_wr), 16'h0007);
  endtask
  task automatic print_verdict();
    if (num_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // main sequence after an eight-cycle reset
  initial begin
    repeat (8) @(negedge clk_in);
    nrst_in = 1'b1;
    repeat (4) @(negedge clk_in);
    t_pages();
    t_dac();
    t_read();
    t_cmds();
    print_verdict();
  end
  // watchdog, roughly three times the expected run
  initial begin
    repeat (40000) @(posedge clk_in);
    num_errors++;
    print_verdict();
  end
endmodule
